/* File: design/dds_device_end.sv */
// Device end: flash die and RAM die answering on one shared bus
`default_nettype none
// How it works
// - Upper RAM lane moves only with upper select
// - Lower RAM lane moves only with lower select
// - Both selects high: RAM data pins stay released
// - RAM stays active while its select low and out of deep power-down
// - Config pin steers access to REFRESH_CONFIG_REG/BUS_CONFIG_REG
// - Flash power-down only from standby, when allowed
// - No new program or erase starts during flash power-down
// - Polarity bit picks power-down level, default low
// - Low program voltage refuses program and erase
// - Program voltage checked only at operation start
// - Host never selects both dies together
// - RAM deselected during all flash cycles
// - Flash deselected during all RAM cycles
// - Flash idle allows any RAM mode
// - RAM idle allows any flash mode
// - Each die answers only its own select
// - RAM power-down on select rise, timed exit
// - Flash reset: outputs off, relock, config default
module dds_device_end
    import dds_pkg::*;
#(
    parameter int RAM_AW   = 4,
    parameter int FL_AW    = 4,
    parameter int EXIT_CYC = RAM_DPD_EXIT_CYC,
    parameter int PROG_CYC = FL_PROG_CYC
) (
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic clkEn,
    dds_bus_if.dev    bus,
    input  wire logic vppAboveEnable,
    input  wire logic vppBelowLockout,
    output logic      ramActive,
    output logic      ramDeepPd,
    output logic      flashDeepPd,
    output logic      flashBusy
);
    localparam int RAM_DEPTH = 1 << RAM_AW;
    localparam int FL_DEPTH  = 1 << FL_AW;
    localparam int CNT_W     = $clog2(EXIT_CYC + 1);
    localparam int PCNT_W    = $clog2(PROG_CYC + 1);

    logic [BUS_W-1:0]  ramMem_q [RAM_DEPTH];
    logic [BUS_W-1:0]  flMem_q  [FL_DEPTH];
    logic [BUS_W-1:0]  addrLo_q;
    logic [AHI_W-1:0]  addrHi_q;
    logic [BUS_W-1:0]  rcr_q;
    logic [BUS_W-1:0]  bcr_q;
    logic [BUS_W-1:0]  ecr_q;
    logic              ramDpd_q;
    logic              ramCsPrev_q;
    logic [CNT_W-1:0]  exitCnt_q;
    logic              flDpd_q;
    logic [LANES-1:0]  lock_q;
    logic              busy_q;
    logic [PCNT_W-1:0] progCnt_q;
    logic              eraseOp_q;
    logic [FL_AW-1:0]  progIdx_q;
    logic [BUS_W-1:0]  progData_q;
    logic [1:0]        vppAbove_s;
    logic [1:0]        vppBelow_s;
    logic [BUS_W-1:0]  devOut_q;
    logic [LANES-1:0]  devOeN_q;
    logic              waitOut_q;
    logic              waitOeN_q;

    logic [BUS_W-1:0]  busIn;
    logic [LANES-1:0]  laneEn;
    logic [RAM_AW-1:0] ramIdx;
    logic [FL_AW-1:0]  flIdx;
    logic              ramSel;
    logic              ramWrite;
    logic              ramRead;
    logic              flSel;
    logic              flWrite;
    logic              flRead;
    logic              flStandby;
    logic              flPdAsserted;
    logic              cfgHit;
    logic              ecrHit;
    logic              unlockHit;
    logic              eraseHit;
    logic              blkSel;
    logic              vppOk;
    logic              startOk;
    logic              progDone;

    // Bus decode; each die looks only at its own select
    assign busIn     = bus.busLevel;
    assign laneEn    = {!bus.upperByteSelN, !bus.lowerByteSelN};
    assign ramSel    = !bus.ramCsN && !ramDpd_q;
    assign ramWrite  = ramSel && bus.latchN && !bus.ramWeN;
    assign ramRead   = ramSel && bus.latchN && !bus.ramOeN && bus.ramWeN;
    assign flSel     = !bus.flashCsN && bus.flashResetN && !flDpd_q;
    assign flWrite   = flSel && bus.latchN && !bus.flashWeN;
    assign flRead    = flSel && bus.latchN && !bus.flashOeN && bus.flashWeN;
    assign flStandby = bus.flashCsN && bus.flashResetN;
    assign ramIdx    = addrLo_q[RAM_AW-1:0];
    assign flIdx     = addrLo_q[FL_AW-1:0];
    assign cfgHit    = addrHi_q[CFG_SEL_BIT];
    assign ecrHit    = (addrLo_q == FL_ECR_ADDR);
    assign unlockHit = (addrLo_q == FL_UNLOCK_ADDR);
    assign eraseHit  = (addrLo_q == FL_ERASE_ADDR);

    // Byte selects gate data only; the die itself stays awake
    assign ramActive = ramSel;
    assign ramDeepPd = ramDpd_q;
    assign flashDeepPd = flDpd_q;
    assign flashBusy = busy_q;

    // Power-down pin level is set by the polarity bit (reset: active low)
    assign flPdAsserted = ecr_q[PD_POL_BIT] ? bus.flashPdIn
                                            : !bus.flashPdIn;

    // Program voltage arrives from an analogue comparator: synchronise
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            vppAbove_s <= 2'h0;
            vppBelow_s <= 2'h3;
        end else if (clkEn) begin
            vppAbove_s <= {vppAbove_s[0], vppAboveEnable};
            vppBelow_s <= {vppBelow_s[0], vppBelowLockout};
        end
    end
    // The band between the two thresholds is treated as unsafe
    assign vppOk = vppAbove_s[1] && !vppBelow_s[1];

    // Address phase, captured while latch is low
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            addrLo_q <= '0;
            addrHi_q <= '0;
        end else if (clkEn && (ramSel || flSel) && !bus.latchN) begin
            addrLo_q <= busIn;
            addrHi_q <= bus.addrHigh;
        end
    end

    // RAM array, written lane by lane
    always_ff @(posedge ref_clk) begin
        if (clkEn && ramWrite && !bus.configAccessPin) begin
            for (int b = 0; b < LANES; b++) begin
                if (laneEn[b]) begin
                    ramMem_q[ramIdx][b*BYTE_W +: BYTE_W] <=
                        busIn[b*BYTE_W +: BYTE_W];
                end
            end
        end
    end

    // RAM configuration registers, picked by the A19 line
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rcr_q <= RCR_RESET;
            bcr_q <= BCR_RESET;
        end else if (clkEn && ramWrite && bus.configAccessPin) begin
            if (cfgHit) bcr_q <= busIn;
            else rcr_q <= busIn;
        end
    end

    // RAM deep power-down: entered on select rise, left after a long low
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ramCsPrev_q <= 1'b1;
            ramDpd_q    <= 1'b0;
            exitCnt_q   <= '0;
        end else if (clkEn) begin
            ramCsPrev_q <= bus.ramCsN;
            if (!ramDpd_q) begin
                if (bus.ramCsN && !ramCsPrev_q && !rcr_q[RCR_DPD_BIT]) begin
                    ramDpd_q  <= 1'b1;
                    exitCnt_q <= '0;
                end
            end else if (bus.ramCsN) begin
                exitCnt_q <= '0;
            end else if (exitCnt_q == CNT_W'(EXIT_CYC - 1)) begin
                ramDpd_q  <= 1'b0;
                exitCnt_q <= '0;
            end else begin
                exitCnt_q <= exitCnt_q + 1'b1;
            end
        end
    end

    // Flash configuration and block locks; reset pin restores both
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ecr_q  <= ECR_RESET;
            lock_q <= '1;
        end else if (clkEn) begin
            if (!bus.flashResetN) begin
                ecr_q  <= ECR_RESET;
                lock_q <= '1;
            end else if (flWrite && ecrHit) begin
                ecr_q <= busIn;
            end else if (flWrite && unlockHit) begin
                lock_q <= lock_q & ~busIn[LANES-1:0];
            end
        end
    end

    // Flash deep power-down; the pin is ignored unless allowed
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            flDpd_q <= 1'b0;
        end else if (clkEn) begin
            if (!bus.flashResetN || !flPdAsserted) begin
                flDpd_q <= 1'b0;
            end else if (flStandby && ecr_q[PD_ALLOW_BIT]) begin
                flDpd_q <= 1'b1;
            end
        end
    end

    // Program/erase engine; voltage is looked at only when starting
    assign blkSel  = eraseHit ? busIn[0] : flIdx[FL_AW-1];
    assign startOk = flWrite && !busy_q && !ecrHit && !unlockHit &&
                     vppOk && !lock_q[blkSel];
    assign progDone = busy_q && (progCnt_q == PCNT_W'(PROG_CYC - 1));

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_q     <= 1'b0;
            progCnt_q  <= '0;
            eraseOp_q  <= 1'b0;
            progIdx_q  <= '0;
            progData_q <= '0;
        end else if (clkEn) begin
            if (!bus.flashResetN) begin
                busy_q <= 1'b0;
            end else if (busy_q) begin
                progCnt_q <= progCnt_q + 1'b1;
                if (progDone) busy_q <= 1'b0;
            end else if (startOk) begin
                busy_q     <= 1'b1;
                progCnt_q  <= '0;
                eraseOp_q  <= eraseHit;
                progIdx_q  <= flIdx;
                progData_q <= busIn;
            end
        end
    end

    // Flash array; programming can only clear bits, erase sets a block
    always_ff @(posedge ref_clk) begin
        if (clkEn && progDone && bus.flashResetN) begin
            if (eraseOp_q) begin
                for (int i = 0; i < FL_DEPTH; i++) begin
                    if (i[FL_AW-1] == progData_q[0]) flMem_q[i] <= '1;
                end
            end else begin
                flMem_q[progIdx_q] <= flMem_q[progIdx_q] & progData_q;
            end
        end
    end

    // Read data and lane drive, registered; released by default
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            devOut_q <= '0;
            devOeN_q <= '1;
        end else if (clkEn) begin
            devOeN_q <= '1;
            if (flRead) begin
                devOeN_q <= '0;
                devOut_q <= ecrHit ? ecr_q : flMem_q[flIdx];
            end else if (ramRead) begin
                devOeN_q <= ~laneEn;
                if (bus.configAccessPin) begin
                    devOut_q <= cfgHit ? bcr_q : rcr_q;
                end else begin
                    devOut_q <= ramMem_q[ramIdx];
                end
            end
        end
    end

    // Wait shows flash busy while selected; released when idle
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            waitOut_q <= 1'b0;
            waitOeN_q <= 1'b1;
        end else if (clkEn) begin
            waitOeN_q <= !(ramSel || flSel);
            waitOut_q <= flSel && busy_q;
        end
    end

    assign bus.devBusOut = devOut_q;
    assign bus.devBusOeN = devOeN_q;
    assign bus.waitOut   = waitOut_q;
    assign bus.waitOeN   = waitOeN_q;
endmodule // dds_device_end
`default_nettype wire

/* File: design/dds_pkg.sv */
// Shared constants and types for the dual-die shared bus pair
`default_nettype none
package dds_pkg;
    // Bus geometry: low word multiplexed, A16..A21 on separate lines
    localparam int BUS_W  = 16;
    localparam int AHI_W  = 6;
    localparam int ADDR_W = BUS_W + AHI_W;
    localparam int BYTE_W = 8;
    localparam int LANES  = 2;

    // Field positions
    localparam int CFG_SEL_BIT  = 3;   // A19 within the high address lines
    localparam int RCR_DPD_BIT  = 4;   // Zero arms RAM deep power-down
    localparam int PD_ALLOW_BIT = 15;  // Flash deep power-down allowed
    localparam int PD_POL_BIT   = 14;  // Flash power-down pin polarity
    localparam int OP_WR_BIT    = 0;
    localparam int OP_FL_BIT    = 2;

    // Reset values
    localparam logic [15:0] RCR_RESET = 16'h0010;
    localparam logic [15:0] BCR_RESET = 16'h0000;
    localparam logic [15:0] ECR_RESET = 16'h0000;

    // Flash special word addresses on the low address word
    localparam logic [15:0] FL_ECR_ADDR    = 16'hFFF0;
    localparam logic [15:0] FL_UNLOCK_ADDR = 16'hFFF1;
    localparam logic [15:0] FL_ERASE_ADDR  = 16'hFFF2;

    // Timing
    localparam int CLK_MHZ          = 20;
    localparam int RAM_DPD_EXIT_NS  = 10000;
    localparam int RAM_DPD_EXIT_CYC = (RAM_DPD_EXIT_NS * CLK_MHZ + 999) / 1000;
    localparam int FL_PROG_NS       = 4200;
    localparam int FL_PROG_CYC      = (FL_PROG_NS * CLK_MHZ + 999) / 1000;

    // Host request kinds
    typedef enum logic [2:0] {
        OP_RAM_RD = 3'h0,
        OP_RAM_WR = 3'h1,
        OP_CFG_RD = 3'h2,
        OP_CFG_WR = 3'h3,
        OP_FL_RD  = 3'h4,
        OP_FL_WR  = 3'h5
    } dds_op_t;
endpackage
`default_nettype wire

/* File: design/dds_bus_if.sv */
// Shared multiplexed bus between host controller and the two dies
`default_nettype none
interface dds_bus_if;
    logic                       ramCsN;
    logic                       flashCsN;
    logic                       latchN;
    logic                       ramWeN;
    logic                       ramOeN;
    logic                       flashWeN;
    logic                       flashOeN;
    logic                       upperByteSelN;
    logic                       lowerByteSelN;
    logic                       configAccessPin;
    logic                       flashResetN;
    logic                       flashPdIn;
    logic [dds_pkg::AHI_W-1:0]  addrHigh;
    logic [dds_pkg::BUS_W-1:0]  hostBusOut;
    logic                       hostBusOeN;
    logic [dds_pkg::BUS_W-1:0]  devBusOut;
    logic [dds_pkg::LANES-1:0]  devBusOeN;
    logic [dds_pkg::BUS_W-1:0]  busLevel;
    logic                       waitOut;
    logic                       waitOeN;
    logic                       waitLevel;

    // Wire resolution per lane; a released lane floats high (pull-up)
    for (genvar b = 0; b < dds_pkg::LANES; b++) begin : g_lane
        assign busLevel[b*dds_pkg::BYTE_W +: dds_pkg::BYTE_W] =
            !hostBusOeN ? hostBusOut[b*dds_pkg::BYTE_W +: dds_pkg::BYTE_W] :
            !devBusOeN[b] ? devBusOut[b*dds_pkg::BYTE_W +: dds_pkg::BYTE_W] :
            {dds_pkg::BYTE_W{1'b1}};
    end
    assign waitLevel = !waitOeN ? waitOut : 1'b1;

    modport dev (
        input  ramCsN, flashCsN, latchN, ramWeN, ramOeN, flashWeN, flashOeN,
        input  upperByteSelN, lowerByteSelN, configAccessPin, flashResetN,
        input  flashPdIn, addrHigh, busLevel,
        output devBusOut, devBusOeN, waitOut, waitOeN
    );
    modport host (
        output ramCsN, flashCsN, latchN, ramWeN, ramOeN, flashWeN, flashOeN,
        output upperByteSelN, lowerByteSelN, configAccessPin, flashResetN,
        output flashPdIn, addrHigh, hostBusOut, hostBusOeN,
        input  busLevel, waitLevel
    );
endinterface
`default_nettype wire

/* File: design/dds_host_end.sv */
// Host end: memory controller that drives the shared bus one die at a time
`default_nettype none
module dds_host_end
    import dds_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire logic              clkEn,
    dds_bus_if.host                bus,
    input  wire logic              reqValid,
    output logic                   reqReady,
    input  wire dds_op_t           reqOp,
    input  wire logic [ADDR_W-1:0] reqAddr,
    input  wire logic [BUS_W-1:0]  reqData,
    input  wire logic [LANES-1:0]  reqByteEn,
    output logic                   rspValid,
    output logic [BUS_W-1:0]       rspData,
    input  wire logic              flashResetReq,
    input  wire logic              flashPdReq,
    input  wire logic              flashPdActiveHigh
);
    typedef enum logic [4:0] {
        ST_IDLE    = 5'b00001,
        ST_LATCH   = 5'b00010,
        ST_ACCESS  = 5'b00100,
        ST_SAMPLE  = 5'b01000,
        ST_RECOVER = 5'b10000
    } dds_hstate_t;

    dds_hstate_t       state_q;
    dds_op_t           op_q;
    logic [ADDR_W-1:0] addr_q;
    logic [BUS_W-1:0]  data_q;
    logic [LANES-1:0]  be_q;
    logic              rspValid_q;
    logic [BUS_W-1:0]  rspData_q;
    logic              flRstN_q;
    logic              pdPin_q;
    logic              inCycle;
    logic              isWr;
    logic              isFl;
    logic              isCfg;

    assign isWr    = op_q[OP_WR_BIT];
    assign isFl    = op_q[OP_FL_BIT];
    assign isCfg   = (op_q == OP_CFG_RD) || (op_q == OP_CFG_WR);
    assign inCycle = state_q inside {ST_LATCH, ST_ACCESS, ST_SAMPLE};
    assign reqReady = (state_q == ST_IDLE);

    // Sequencer; the recover cycle gives the die time to release the bus
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
        end else if (clkEn) begin
            unique case (state_q)
                ST_IDLE:    if (reqValid) state_q <= ST_LATCH;
                ST_LATCH:   state_q <= ST_ACCESS;
                ST_ACCESS:  state_q <= isWr ? ST_RECOVER : ST_SAMPLE;
                ST_SAMPLE:  state_q <= ST_RECOVER;
                ST_RECOVER: state_q <= ST_IDLE;
            endcase
        end
    end

    // Request capture
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            op_q   <= OP_RAM_RD;
            addr_q <= '0;
            data_q <= '0;
            be_q   <= '0;
        end else if (clkEn && reqReady && reqValid) begin
            op_q   <= reqOp;
            addr_q <= reqAddr;
            data_q <= reqData;
            be_q   <= reqByteEn;
        end
    end

    // Answer; read data is taken one cycle after the die starts driving
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rspValid_q <= 1'b0;
            rspData_q  <= '0;
        end else if (clkEn) begin
            rspValid_q <= (state_q == ST_SAMPLE) ||
                          (state_q == ST_ACCESS && isWr);
            if (state_q == ST_SAMPLE) rspData_q <= bus.busLevel;
        end
    end
    assign rspValid = rspValid_q;
    assign rspData  = rspData_q;

    // Flash reset and power-down pins, power-down polarity chosen by the user
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            flRstN_q <= 1'b0;
            pdPin_q  <= 1'b1;
        end else if (clkEn) begin
            flRstN_q <= !flashResetReq;
            pdPin_q  <= flashPdActiveHigh ? flashPdReq : !flashPdReq;
        end
    end
    assign bus.flashResetN = flRstN_q;
    assign bus.flashPdIn   = pdPin_q;

    // Only the addressed die is ever selected; the other stays off
    assign bus.ramCsN   = !(inCycle && !isFl);
    assign bus.flashCsN = !(inCycle && isFl);
    assign bus.latchN   = (state_q != ST_LATCH);
    assign bus.ramWeN   = !(state_q == ST_ACCESS && isWr && !isFl);
    assign bus.flashWeN = !(state_q == ST_ACCESS && isWr && isFl);
    assign bus.ramOeN   = !((state_q inside {ST_ACCESS, ST_SAMPLE}) &&
                            !isWr && !isFl);
    assign bus.flashOeN = !((state_q inside {ST_ACCESS, ST_SAMPLE}) &&
                            !isWr && isFl);
    // Byte selects idle high so the RAM lanes stay released
    assign bus.upperByteSelN   = !(inCycle && !isFl && be_q[1]);
    assign bus.lowerByteSelN   = !(inCycle && !isFl && be_q[0]);
    assign bus.configAccessPin = inCycle && isCfg;
    assign bus.addrHigh   = inCycle ? addr_q[ADDR_W-1:BUS_W] : '0;
    assign bus.hostBusOut = (state_q == ST_LATCH) ? addr_q[BUS_W-1:0] : data_q;
    assign bus.hostBusOeN = !((state_q == ST_LATCH) ||
                              (state_q == ST_ACCESS && isWr));
endmodule // dds_host_end
`default_nettype wire

/* File: tb/dds_sva.sv */
// Bus checker for the shared bus between host end and device end
`default_nettype none
module dds_sva
    import dds_pkg::*;
(
    input wire logic             ref_clk,
    input wire logic             rst_b,
    input wire logic             ramCsN,
    input wire logic             flashCsN,
    input wire logic             upperByteSelN,
    input wire logic             lowerByteSelN,
    input wire logic             flashResetN,
    input wire logic [LANES-1:0] devBusOeN,
    input wire logic             waitOeN
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // Lane drive must trace back to that lane's select one edge earlier
    a_upper_gate: assert property (
        !devBusOeN[1] && $past(!ramCsN) |-> $past(!upperByteSelN))
        else $error("upper lane driven while unselected");
    a_lower_gate: assert property (
        !devBusOeN[0] && $past(!ramCsN) |-> $past(!lowerByteSelN))
        else $error("lower lane driven while unselected");
    a_both_off: assert property (
        $past(upperByteSelN && lowerByteSelN && flashCsN) |-> &devBusOeN)
        else $error("bus driven with both lanes off");
    // Idle or held-in-reset flash must leave the pins free
    a_idle_release: assert property (
        $past(ramCsN && flashCsN) |-> &devBusOeN && waitOeN)
        else $error("bus or wait driven with no die selected");
    a_reset_quiet: assert property (
        $past(!flashResetN && ramCsN) |-> &devBusOeN)
        else $error("flash drives bus while in reset");
    a_one_die: assert property (!ramCsN |-> flashCsN)
        else $error("both dies selected");
    a_ram_off: assert property (!flashCsN |=> ramCsN || flashCsN)
        else $error("ram selected during flash cycle");
    a_flash_off: assert property (!ramCsN |=> flashCsN || ramCsN)
        else $error("flash selected during ram cycle");

    c_ram_read: cover property ($past(!ramCsN) && !devBusOeN[0]);
    c_fl_read: cover property ($past(!flashCsN) && !devBusOeN[1]);
    c_lanes_off: cover property (!ramCsN && upperByteSelN && lowerByteSelN);
endmodule // dds_sva
`default_nettype wire

/* File: tb/dual_die_shared_bus_select_test.sv */
// Self-checking bench for the host end and device end pair
`default_nettype none
module dual_die_shared_bus_select_test;
    import dds_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst_b, reqValid, reqReady, rspValid, seenActive;
    logic flashResetReq, flashPdReq, flashPdActiveHigh;
    logic vppAboveEnable, vppBelowLockout;
    logic ramActive, ramDeepPd, flashDeepPd, flashBusy;
    dds_op_t reqOp;
    logic [ADDR_W-1:0] reqAddr;
    logic [BUS_W-1:0] reqData, rspData;
    logic [LANES-1:0] reqByteEn;
    int num_errors = 0;
    int checks_done = 0;
    dds_bus_if bus ();
    dds_host_end i_dds_host_end (.ref_clk, .rst_b, .clkEn(1'b1), .bus(bus),
        .reqValid, .reqReady, .reqOp, .reqAddr, .reqData, .reqByteEn,
        .rspValid, .rspData, .flashResetReq, .flashPdReq, .flashPdActiveHigh);
    // Short exit and program counts keep the run brief
    dds_device_end #(.EXIT_CYC(4), .PROG_CYC(4)) i_dds_device_end (.ref_clk,
        .rst_b, .clkEn(1'b1), .bus(bus), .vppAboveEnable, .vppBelowLockout,
        .ramActive, .ramDeepPd, .flashDeepPd, .flashBusy);
    dds_sva i_dds_sva (.ref_clk, .rst_b, .ramCsN(bus.ramCsN),
        .flashCsN(bus.flashCsN), .upperByteSelN(bus.upperByteSelN),
        .lowerByteSelN(bus.lowerByteSelN), .flashResetN(bus.flashResetN),
        .devBusOeN(bus.devBusOeN), .waitOeN(bus.waitOeN));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic tmo;
        num_errors++;
        $display("unexpected at %0t: wait ran out", $time);
        summarize();
    endtask
    // One host request; reads compare the returned word
    task automatic op(input dds_op_t o, input logic [21:0] a,
        input logic [15:0] d, input logic [1:0] be, input logic [15:0] e);
        int n;
        n = 0;
        while (!reqReady && n < 20) begin @(negedge ref_clk); n++; end
        {reqOp, reqAddr, reqData, reqByteEn, reqValid} = {o, a, d, be, 1'b1};
        @(negedge ref_clk);
        reqValid = 1'b0;
        for (n = 0; n < 20 && rspValid !== 1'b1; n++) begin
            seenActive |= ramActive;
            @(negedge ref_clk);
        end
        if (n == 20) tmo();
        if (!o[OP_WR_BIT]) chk(rspData, e);
    endtask
    // Bounded wait for the flash to finish a program or erase
    task automatic idle;
        int n;
        for (n = 0; n < 100 && flashBusy !== 1'b0; n++) @(negedge ref_clk);
        if (n == 100) tmo();
    endtask
    task automatic vpp(input logic ok);
        {vppAboveEnable, vppBelowLockout} = {ok, !ok};
        repeat (4) @(negedge ref_clk);
    endtask
    task automatic t_ram;
        op(OP_RAM_WR, 22'h0002, 16'h1234, 2'b11, 16'h0000);
        op(OP_RAM_RD, 22'h0002, 16'h0000, 2'b01, 16'hFF34);
        op(OP_RAM_RD, 22'h0002, 16'h0000, 2'b10, 16'h12FF);
        op(OP_RAM_WR, 22'h0002, 16'hABCD, 2'b10, 16'h0000);
        op(OP_RAM_WR, 22'h0002, 16'h0000, 2'b00, 16'h0000);
        op(OP_RAM_RD, 22'h0002, 16'h0000, 2'b11, 16'hAB34);
        seenActive = 1'b0;
        op(OP_RAM_RD, 22'h0002, 16'h0000, 2'b00, 16'hFFFF);
        chk({15'h0000, seenActive}, 16'h0001);
        op(OP_CFG_WR, 22'h08_0000, 16'h00A5, 2'b11, 16'h0000);
        op(OP_CFG_RD, 22'h08_0000, 16'h0000, 2'b11, 16'h00A5);
        op(OP_CFG_RD, 22'h00_0000, 16'h0000, 2'b11, 16'h0010);
        $display("test ram done");
    endtask
    task automatic t_flash;
        op(OP_FL_WR, 22'hFFF1, 16'h0003, 2'b11, 16'h0000);
        op(OP_FL_WR, 22'hFFF2, 16'h0000, 2'b11, 16'h0000);
        idle();
        op(OP_FL_WR, 22'h0001, 16'h5A5A, 2'b11, 16'h0000);
        idle();
        vpp(1'b0);
        op(OP_FL_WR, 22'h0001, 16'h0000, 2'b11, 16'h0000);
        idle();
        op(OP_FL_RD, 22'h0001, 16'h0000, 2'b11, 16'h5A5A);
        vpp(1'b1);
        op(OP_FL_WR, 22'h0001, 16'h0A0A, 2'b11, 16'h0000);
        vpp(1'b0);
        idle();
        op(OP_FL_RD, 22'h0001, 16'h0000, 2'b11, 16'h0A0A);
        $display("test flash done");
    endtask
    // Power-down pin first ignored, then honoured at high polarity
    task automatic t_pd;
        vpp(1'b1);
        {flashPdActiveHigh, flashPdReq} = 2'b11;
        vpp(1'b1);
        chk({15'h0000, flashDeepPd}, 16'h0000);
        flashPdReq = 1'b0;
        op(OP_FL_WR, 22'hFFF0, 16'hC000, 2'b11, 16'h0000);
        flashPdReq = 1'b1;
        vpp(1'b1);
        chk({15'h0000, flashDeepPd}, 16'h0001);
        op(OP_FL_WR, 22'h0001, 16'h0000, 2'b11, 16'h0000);
        // Pin low releases power-down while the polarity bit says high
        {flashPdActiveHigh, flashPdReq} = 2'b10;
        vpp(1'b1);
        op(OP_FL_RD, 22'h0001, 16'h0000, 2'b11, 16'h0A0A);
        flashResetReq = 1'b1;
        vpp(1'b1);
        flashResetReq = 1'b0;
        vpp(1'b1);
        op(OP_FL_RD, 22'hFFF0, 16'h0000, 2'b11, 16'h0000);
        op(OP_FL_WR, 22'h0001, 16'h0000, 2'b11, 16'h0000);
        idle();
        op(OP_FL_RD, 22'h0001, 16'h0000, 2'b11, 16'h0A0A);
        // Arming deep power-down last: nothing here holds the select long
        op(OP_CFG_WR, 22'h00_0000, 16'h0000, 2'b11, 16'h0000);
        // Entry happens on the select rise, one edge after the answer
        @(negedge ref_clk);
        chk({15'h0000, ramDeepPd}, 16'h0001);
        op(OP_RAM_RD, 22'h0002, 16'h0000, 2'b11, 16'hFFFF);
        $display("test power-down done");
    endtask
    initial begin
        {rst_b, reqValid, flashResetReq, flashPdReq} = 4'b0000;
        {flashPdActiveHigh, reqByteEn, seenActive} = 4'b0000;
        {reqOp, reqAddr, reqData} = '0;
        {vppAboveEnable, vppBelowLockout} = 2'b10;
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_b = 1'b1;
        t_ram();
        t_flash();
        t_pd();
        summarize();
    end
endmodule // dual_die_shared_bus_select_test
`default_nettype wire
